// file: rtl/ffd_pkg.sv
// Constants shared by the final decimator, its host model and its testbench
package ffd_pkg;

  // ==========================================================================
  // Datapath geometry
  localparam int TAPS = 128;
  localparam int COEF_W = 32;
  localparam int SAMPLE_W = 24;
  localparam int ACC_W = 64;
  localparam int MAC_LANES = 2;
  localparam int TAP_IDX_W = 7;
  localparam int MAC_CNT_W = 6;

  // ==========================================================================
  // Register port
  localparam logic [7:0] FIR_COEF_PORT_ADDR = 8'h13;
  localparam int COEF_BYTES = 512;
  localparam logic [8:0] PTR_RESET = 9'h000;
  localparam logic [COEF_W-1:0] COEF_RESET = 32'h0000_0000;

  // ==========================================================================
  // Coefficient source encodings
  localparam logic [2:0] SRC_PRESET = 3'h0;
  localparam logic [2:0] SRC_USER = 3'h7;

  // ==========================================================================
  // Preset set: unity impulse at twice the group delay in input samples
  localparam logic [6:0] GROUP_DELAY_PERIODS = 7'h22;
  localparam logic [6:0] PRESET_CENTER_TAP = 7'h44;
  localparam logic [COEF_W-1:0] PRESET_UNITY = 32'h7fff_ffff;

  // ==========================================================================
  // Latency, suppression and settling counts
  localparam logic [6:0] LAT_PRESET_PERIODS = 7'h44;
  localparam logic [6:0] LAT_USER_PERIODS = 7'h4b;
  localparam logic [6:0] UNSETTLED_CONV = 7'h45;
  localparam logic [6:0] OUT_CNT_MAX = 7'h7f;
  localparam logic [4:0] OVH_CLKS = 5'h10;
  localparam logic [4:0] BUF_EXTRA_CLKS = 5'h08;

  // ==========================================================================
  // Oversampling ratio decode
  localparam logic [10:0] OSR_BASE = 11'h020;
  localparam logic [4:0] OSR_MAX_CODE = 5'h05;

endpackage

// file: rtl/ffd_tgl_sync.sv
// Toggle synchroniser turning a far-domain toggle into a local pulse
`timescale 1ns/100ps
`default_nettype none
module ffd_tgl_sync (
  // Local clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Far-domain toggle
  input wire logic tgl_i,
  // Local one-cycle pulse
  output logic pulse_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ffd_sync_state_t;

  ffd_sync_state_t st_reg;
  ffd_sync_state_t st_next;

  // Three-stage chain; only stage two feeds the edge detector besides stage three
  always_comb begin
    st_next = st_reg;
    st_next.s1 = tgl_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Event when the two settled stages disagree
  assign pulse_o = st_reg.s2 ^ st_reg.s3;
endmodule // ffd_tgl_sync
`default_nettype wire

// file: rtl/ffd_final_decimator.sv
// Final 128-tap decimate-by-two FIR stage with coefficient bank port
//
// Overview of operation
// - 128-tap FIR, output on every second input, halving the rate.
// - Bypass skips filtering and decimation, passing each sample unchanged.
// - Coefficients are 32-bit signed 1.31 values, 80000000h to 7FFFFFFFh.
// - First output after sync: 75 or 68 output periods plus 16 clocks.
// - Source field 000b picks preset coefficients, 111b the loaded ones.
// - Five-bit oversampling field sets overall ratio and output data rate.
// - One address 13h reaches a 512-byte bank of 128 coefficients.
// - Each completed port access advances the byte pointer by one.
// - Bytes run MSB first from the highest coefficient down to h0.
// - Access to any other address returns the pointer to byte one.
// - Clearing the serial error flag restarts the coefficient transfer.
// - Preset set has 34-period group delay, settles 68 periods after step.
// - Sync restarts the filter and withholds the first 68 (preset) or 75 (loaded) conversions.
// - Suppression adds sixteen converter clock cycles at every rate.
// - Unsynchronised change marks next 69 conversions unsettled, not suppressed.
// - Preset response is flat: a pure delay with no passband or stopband corner.
// - Upstream half-band ratio is the programmed ratio divided by two.
// - Enabled input buffers add eight converter clocks of latency.
`timescale 1ns/100ps
`default_nettype none
module ffd_final_decimator
  import ffd_pkg::*;
(
  // System clock domain
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Converter clock domain
  input wire logic conv_clk_i,
  input wire logic conv_resetn_i,
  // Register access from the serial framing logic
  input wire logic reg_sel_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic serial_err_clear_i,
  // Configuration fields
  input wire logic [4:0] oversampling_ratio_field_i,
  input wire logic [2:0] coefficient_source_field_i,
  input wire logic bypass_i,
  input wire logic input_buffer_en_i,
  // Upstream stream and synchronisation, converter domain
  input wire logic [ffd_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic sync_i,
  // Output stream and rate information
  output logic [ffd_pkg::SAMPLE_W-1:0] data_o,
  output logic data_valid_o,
  output logic data_settled_o,
  output logic [10:0] osr_ratio_o,
  output logic [10:0] halfband_ratio_o,
  output logic [11:0] out_period_clk_o
);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {FFD_IDLE, FFD_MAC, FFD_OUT} ffd_phase_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] hold;
    logic samp_tgl;
    logic sync_tgl;
    logic tick_tgl;
  } ffd_conv_state_t;

  typedef struct packed {
    ffd_phase_t state;
    logic [8:0] ptr;
    logic [7:0] rdata;
    logic rvalid;
    logic [TAP_IDX_W-1:0] wptr;
    logic [TAP_IDX_W-1:0] base;
    logic odd;
    logic [MAC_CNT_W-1:0] mac_cnt;
    logic signed [ACC_W-1:0] acc;
    logic [6:0] out_cnt;
    logic [4:0] ovh_cnt;
    logic suppress;
    logic [6:0] unsettled;
    logic [SAMPLE_W-1:0] data;
    logic dvalid;
    logic settled;
    logic [2:0] prev_src;
    logic prev_byp;
    logic [10:0] osr;
    logic [10:0] halfband;
    logic [11:0] period;
  } ffd_sys_state_t;

  // ==========================================================================
  // Storage and state
  logic [COEF_W-1:0] coef_mem [TAPS];
  logic [SAMPLE_W-1:0] hist [TAPS];
  ffd_conv_state_t cv_reg;
  ffd_conv_state_t cv_next;
  ffd_sys_state_t st_reg;
  ffd_sys_state_t st_next;
  logic samp_p;
  logic sync_p;
  logic tick_p;
  logic port_hit;
  logic port_wr;
  logic signed [ACC_W-1:0] lane_prod [MAC_LANES];

  // ==========================================================================
  // Functions
  // Preset set is a pure delay: flat response, constant group delay
  function automatic logic [COEF_W-1:0] preset_coef(input logic [TAP_IDX_W-1:0] t);
    preset_coef = (t == PRESET_CENTER_TAP) ? PRESET_UNITY : COEF_RESET;
  endfunction

  // Coefficient for a tap under the selected source
  function automatic logic [COEF_W-1:0] tap_coef(input logic [TAP_IDX_W-1:0] t);
    tap_coef = (coefficient_source_field_i == SRC_USER) ? coef_mem[t] : preset_coef(t);
  endfunction

  // Coefficient index addressed by a byte pointer, highest first
  function automatic logic [TAP_IDX_W-1:0] ptr_coef(input logic [8:0] p);
    ptr_coef = 7'h7f - p[8:2];
  endfunction

  // Bit offset of the byte addressed by a pointer, MSB first
  function automatic logic [4:0] ptr_lane(input logic [8:0] p);
    ptr_lane = {~p[1:0], 3'h0};
  endfunction

  // Ratio from the oversampling field, codes above the top clamp to it
  function automatic logic [10:0] osr_decode(input logic [4:0] f);
    logic [4:0] c;
    c = (f > OSR_MAX_CODE) ? OSR_MAX_CODE : f;
    osr_decode = OSR_BASE << c;
  endfunction

  // ==========================================================================
  // Converter domain: hold each sample and flag events by toggles
  always_comb begin
    cv_next = cv_reg;
    cv_next.tick_tgl = ~cv_reg.tick_tgl; // One toggle per converter clock
    if (sample_valid_i) begin
      cv_next.hold = sample_i;
      cv_next.samp_tgl = ~cv_reg.samp_tgl;
    end
    if (sync_i) begin
      cv_next.sync_tgl = ~cv_reg.sync_tgl;
    end
  end

  // Converter domain register
  always_ff @(posedge conv_clk_i) begin
    if (!conv_resetn_i) begin
      cv_reg <= '0;
    end else begin
      cv_reg <= cv_next;
    end
  end

  // ==========================================================================
  // Crossings into the system domain
  ffd_tgl_sync u_samp_sync (
    .clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .tgl_i(cv_reg.samp_tgl),
    .pulse_o(samp_p)
  );

  ffd_tgl_sync u_sync_sync (
    .clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .tgl_i(cv_reg.sync_tgl),
    .pulse_o(sync_p)
  );

  ffd_tgl_sync u_tick_sync (
    .clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .tgl_i(cv_reg.tick_tgl),
    .pulse_o(tick_p)
  );

  // ==========================================================================
  // Port decode
  assign port_hit = reg_sel_i && (reg_addr_i == FIR_COEF_PORT_ADDR);
  assign port_wr = port_hit && reg_write_i && !serial_err_clear_i;

  // Parallel tap lanes: lane g handles taps g*64 + mac_cnt
  genvar g;
  generate
    for (g = 0; g < MAC_LANES; g++) begin : g_lane
      logic [TAP_IDX_W-1:0] tap;
      logic signed [COEF_W+SAMPLE_W-1:0] prod;
      assign tap = {g[0], st_reg.mac_cnt};
      assign prod = $signed(tap_coef(tap)) * $signed(hist[st_reg.base - tap]);
      assign lane_prod[g] = ACC_W'(prod);
    end
  endgenerate

  // ==========================================================================
  // System domain next-state logic
  always_comb begin
    logic signed [ACC_W-1:0] sum;
    logic [6:0] lat;
    logic [4:0] ovh;
    logic sat_hi;
    logic sat_lo;
    sum = st_reg.acc;
    lat = (coefficient_source_field_i == SRC_USER) ? LAT_USER_PERIODS : LAT_PRESET_PERIODS;
    ovh = input_buffer_en_i ? (OVH_CLKS + BUF_EXTRA_CLKS) : OVH_CLKS;
    sat_hi = !st_reg.acc[ACC_W-1] && (st_reg.acc[ACC_W-2:54] != '0);
    sat_lo = st_reg.acc[ACC_W-1] && (st_reg.acc[ACC_W-2:54] != '1);
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.dvalid = 1'b0;

    // Rate information
    st_next.osr = osr_decode(oversampling_ratio_field_i);
    st_next.halfband = st_next.osr >> 1;
    st_next.period = {st_next.osr, 1'b0};

    // Coefficient port: read answer and pointer movement
    if (reg_sel_i) begin
      if (port_hit) begin
        if (!reg_write_i) begin
          st_next.rdata = coef_mem[ptr_coef(st_reg.ptr)][ptr_lane(st_reg.ptr) +: 8];
          st_next.rvalid = 1'b1;
        end
        st_next.ptr = st_reg.ptr + 9'h001;
      end else begin
        st_next.ptr = PTR_RESET;
      end
    end
    if (serial_err_clear_i) begin
      st_next.ptr = PTR_RESET;
    end

    // Suppression overhead counted in converter clocks
    if (tick_p && (st_reg.ovh_cnt != '0)) begin
      st_next.ovh_cnt = st_reg.ovh_cnt - 5'h01;
    end
    if (st_reg.suppress && (st_reg.ovh_cnt == '0) && (st_reg.out_cnt >= lat)) begin
      st_next.suppress = 1'b0;
    end

    // Unsynchronised change of source or bypass leaves data unsettled
    st_next.prev_src = coefficient_source_field_i;
    st_next.prev_byp = bypass_i;
    if ((coefficient_source_field_i != st_reg.prev_src) || (bypass_i != st_reg.prev_byp)) begin
      st_next.unsettled = UNSETTLED_CONV;
    end

    // Filter sequencing
    case (st_reg.state)
      FFD_IDLE: begin
        if (samp_p && !bypass_i) begin
          st_next.wptr = st_reg.wptr + 7'h01;
          st_next.odd = ~st_reg.odd;
          if (st_reg.odd) begin
            st_next.base = st_reg.wptr;
            st_next.acc = '0;
            st_next.mac_cnt = '0;
            st_next.state = FFD_MAC;
          end
        end
      end
      FFD_MAC: begin
        for (int i = 0; i < MAC_LANES; i++) begin
          sum = sum + lane_prod[i];
        end
        st_next.acc = sum;
        st_next.mac_cnt = st_reg.mac_cnt + 6'h01;
        if (st_reg.mac_cnt == 6'h3f) begin
          st_next.state = FFD_OUT;
        end
      end
      FFD_OUT: begin
        if (sat_hi) begin
          st_next.data = {1'b0, {(SAMPLE_W-1){1'b1}}};
        end else if (sat_lo) begin
          st_next.data = {1'b1, {(SAMPLE_W-1){1'b0}}};
        end else begin
          st_next.data = st_reg.acc[54:31]; // 1.31 scaling
        end
        st_next.dvalid = !st_reg.suppress;
        st_next.settled = (st_reg.unsettled == '0);
        if (st_reg.unsettled != '0) begin
          st_next.unsettled = st_reg.unsettled - 7'h01;
        end
        if (st_reg.out_cnt != OUT_CNT_MAX) begin
          st_next.out_cnt = st_reg.out_cnt + 7'h01;
        end
        st_next.state = FFD_IDLE;
      end
      default: begin
        st_next.state = FFD_IDLE;
      end
    endcase

    // Bypass passes each sample straight through
    if (samp_p && bypass_i) begin
      st_next.data = cv_reg.hold;
      st_next.dvalid = 1'b1;
      st_next.settled = (st_reg.unsettled == '0);
      if (st_reg.unsettled != '0) begin
        st_next.unsettled = st_reg.unsettled - 7'h01;
      end
    end

    // Synchronisation restarts the filter with the present coefficients
    if (sync_p) begin
      st_next.state = FFD_IDLE;
      st_next.wptr = '0;
      st_next.odd = 1'b0;
      st_next.acc = '0;
      st_next.out_cnt = '0;
      st_next.ovh_cnt = ovh;
      st_next.suppress = 1'b1;
      st_next.unsettled = '0;
      st_next.dvalid = 1'b0;
    end
  end

  // System domain state register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Coefficient bank and sample history
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < TAPS; i++) begin
        coef_mem[i] <= COEF_RESET;
      end
    end else if (port_wr) begin
      coef_mem[ptr_coef(st_reg.ptr)][ptr_lane(st_reg.ptr) +: 8] <= reg_wdata_i;
    end
  end

  // History is cleared by sync so the restart sees no stale samples
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || sync_p) begin
      for (int i = 0; i < TAPS; i++) begin
        hist[i] <= '0;
      end
    end else if (samp_p && !bypass_i && (st_reg.state == FFD_IDLE)) begin
      hist[st_reg.wptr] <= cv_reg.hold;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o = st_reg.rdata;
  assign reg_rvalid_o = st_reg.rvalid;
  assign data_o = st_reg.data;
  assign data_valid_o = st_reg.dvalid;
  assign data_settled_o = st_reg.settled;
  assign osr_ratio_o = st_reg.osr;
  assign halfband_ratio_o = st_reg.halfband;
  assign out_period_clk_o = st_reg.period;

endmodule // ffd_final_decimator
`default_nettype wire

// file: tb/ffd_monitor.sv
// Port checks for the final decimator, bound into the design
`timescale 1ns/100ps
`default_nettype none
module ffd_monitor (
  // Clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic reg_sel_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic serial_err_clear_i,
  // Configuration, sync and output stream
  input wire logic [4:0] oversampling_ratio_field_i,
  input wire logic sync_i,
  input wire logic data_valid_o,
  input wire logic [10:0] osr_ratio_o,
  input wire logic [10:0] halfband_ratio_o,
  input wire logic [11:0] out_period_clk_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [10:0] osr_exp;
  // Expected ratio for the field code, large codes clamp
  always_comb osr_exp = (oversampling_ratio_field_i > 5'h05) ? 11'h400
    : 11'h020 << oversampling_ratio_field_i;
  // ==========================================================
  // Register port
  a_read_answer: assert property (reg_sel_i && !reg_write_i && reg_addr_i == 8'h13
    && !serial_err_clear_i |=> reg_rvalid_o) else $error("port read not answered");
  a_write_silent: assert property (reg_sel_i && reg_write_i |=> !reg_rvalid_o)
    else $error("write answered");
  a_other_silent: assert property (reg_sel_i && reg_addr_i != 8'h13
    |=> !reg_rvalid_o) else $error("other address answered");
  a_rdata_holds: assert property ($changed(reg_rdata_o) |-> reg_rvalid_o)
    else $error("read data moved without answer");
  // ==========================================================
  // Rates and stream
  a_osr_decode: assert property (resetn_i |=> osr_ratio_o == $past(osr_exp))
    else $error("ratio decode wrong");
  a_hb_half: assert property (halfband_ratio_o == osr_ratio_o >> 1)
    else $error("half-band ratio wrong");
  a_period_twice: assert property (out_period_clk_o == {osr_ratio_o, 1'b0})
    else $error("output period wrong");
  a_valid_pulse: assert property (data_valid_o |=> !data_valid_o)
    else $error("output valid too long");
  a_sync_withhold: assert property ($rose(sync_i) |-> ##10 !data_valid_o [*8])
    else $error("output shortly after sync");
endmodule // ffd_monitor
bind ffd_final_decimator ffd_monitor u_mon (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .reg_sel_i(reg_sel_i), .reg_write_i(reg_write_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .serial_err_clear_i(serial_err_clear_i),
  .oversampling_ratio_field_i(oversampling_ratio_field_i), .sync_i(sync_i),
  .data_valid_o(data_valid_o), .osr_ratio_o(osr_ratio_o),
  .halfband_ratio_o(halfband_ratio_o), .out_period_clk_o(out_period_clk_o));
`default_nettype wire

// file: tb/ffd_host_model.sv
// Host controller model that loads and reads the coefficient port
`timescale 1ns/100ps
`default_nettype none
module ffd_host_model
  import ffd_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register port
  output logic sel_o,
  output logic write_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic err_clear_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  // Idle port at time zero
  initial begin
    sel_o = 0;
    write_o = 0;
    addr_o = 8'h00;
    wdata_o = 8'hff;
    err_clear_o = 0;
  end
  // One access, answer taken one edge later, then the frame gap
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic v);
    @(posedge clk_i);
    sel_o <= 1;
    write_o <= w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    sel_o <= 0;
    wdata_o <= ~d;
    @(posedge clk_i);
    q = rdata_i;
    v = rvalid_i;
    repeat (31) @(posedge clk_i);
  endtask
  // Clear of the serial error flag
  task automatic clr;
    @(posedge clk_i);
    err_clear_o <= 1;
    @(posedge clk_i);
    err_clear_o <= 0;
    repeat (31) @(posedge clk_i);
  endtask
  // Whole bank: one tap set, all others padded with zero
  task automatic load(input int tap, input logic [31:0] val);
    logic [7:0] q;
    logic v;
    acc(0, 8'h00, 8'h00, q, v);
    for (int k = 0; k < 512; k++)
      acc(1, FIR_COEF_PORT_ADDR, (127 - k / 4 == tap) ? val[31 - 8 * (k % 4) -: 8]
        : 8'h00, q, v);
  endtask
endmodule // ffd_host_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the final decimator
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module testbench;
  import ffd_pkg::*;
  logic sys_clk_i = 0;
  logic conv_clk_i = 0;
  logic resetn_i, conv_resetn_i, reg_sel_i, reg_write_i, reg_rvalid_o, serial_err_clear_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [4:0] oversampling_ratio_field_i;
  logic [2:0] coefficient_source_field_i;
  logic bypass_i, input_buffer_en_i, sample_valid_i, sync_i, data_valid_o, data_settled_o;
  logic [SAMPLE_W-1:0] sample_i, data_o, last_d;
  logic [10:0] osr_ratio_o, halfband_ratio_o;
  logic [11:0] out_period_clk_o;
  logic last_s;
  int errors = 0;
  int cmp_count = 0;
  int vcnt = 0;
  // Clocks: converter clock offset so edges never meet
  always #2.5 sys_clk_i = ~sys_clk_i;
  initial begin
    #1.1;
    forever #7.5 conv_clk_i = ~conv_clk_i;
  end
  ffd_final_decimator uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .conv_clk_i(conv_clk_i), .conv_resetn_i(conv_resetn_i), .reg_sel_i(reg_sel_i),
    .reg_write_i(reg_write_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .serial_err_clear_i(serial_err_clear_i),
    .oversampling_ratio_field_i(oversampling_ratio_field_i),
    .coefficient_source_field_i(coefficient_source_field_i), .bypass_i(bypass_i),
    .input_buffer_en_i(input_buffer_en_i), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .sync_i(sync_i), .data_o(data_o),
    .data_valid_o(data_valid_o), .data_settled_o(data_settled_o),
    .osr_ratio_o(osr_ratio_o), .halfband_ratio_o(halfband_ratio_o),
    .out_period_clk_o(out_period_clk_o));
  ffd_host_model host (.clk_i(sys_clk_i), .sel_o(reg_sel_i), .write_o(reg_write_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .err_clear_o(serial_err_clear_i),
    .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));
  // Output capture
  always @(posedge sys_clk_i) if (data_valid_o === 1'b1) begin
    vcnt <= vcnt + 1;
    last_d <= data_o;
    last_s <= data_settled_o;
  end
  // One sample pulse, line shows the inverse when idle
  task automatic samp(input logic [SAMPLE_W-1:0] v);
    @(posedge conv_clk_i);
    sample_i <= v;
    sample_valid_i <= 1;
    @(posedge conv_clk_i);
    sample_i <= ~v;
    sample_valid_i <= 0;
    repeat (30) @(posedge conv_clk_i);
  endtask
  // Sync, then lat + 2 constant input pairs, noting the pair at which the first output shows
  task automatic filt(input int lat);
    int base, first;
    base = vcnt;
    first = 0;
    @(posedge conv_clk_i);
    sync_i <= 1;
    @(posedge conv_clk_i);
    sync_i <= 0;
    for (int p = 1; p <= lat + 2; p++) begin
      samp(24'h100000);
      samp(24'h100000);
      if (first == 0 && vcnt != base) first = p;
    end
    `CHK(first >= lat && first <= lat + 1, 1'b1)
    `CHK(last_d, 24'h0fffff)
    `CHK(last_s, 1'b1)
  endtask
  task automatic t_osr;
    for (int c = 0; c < 6; c++) begin
      @(posedge sys_clk_i);
      oversampling_ratio_field_i <= 5'(c);
      repeat (3) @(posedge sys_clk_i);
      `CHK(osr_ratio_o, 11'h020 << c)
      `CHK(halfband_ratio_o, 11'h010 << c)
      `CHK(out_period_clk_o, 12'h040 << c)
    end
    // Codes above the top ratio clamp to it
    @(posedge sys_clk_i);
    oversampling_ratio_field_i <= 5'h1f;
    repeat (3) @(posedge sys_clk_i);
    `CHK(osr_ratio_o, 11'h400)
    $display("test osr done");
  endtask
  task automatic t_bypass;
    logic [SAMPLE_W-1:0] v;
    int base;
    bypass_i <= 1;
    for (int i = 0; i < 4; i++) begin
      v = {i[7:0] ^ 8'h80, 16'h5a3c};
      base = vcnt;
      samp(v);
      `CHK(vcnt - base, 1)
      `CHK(last_d, v)
      `CHK(last_s, 1'b0)
    end
    bypass_i <= 0;
    $display("test bypass done");
  endtask
  task automatic t_reg;
    logic [7:0] q;
    logic v;
    for (int k = 0; k < 512; k++) host.acc(1, FIR_COEF_PORT_ADDR, 8'(k) ^ 8'h5a, q, v);
    for (int k = 0; k < 6; k++) begin
      host.acc(0, FIR_COEF_PORT_ADDR, 8'h00, q, v);
      `CHK(v, 1'b1)
      `CHK(q, 8'(k) ^ 8'h5a)
    end
    host.acc(0, 8'h12, 8'h00, q, v);
    `CHK(v, 1'b0)
    host.acc(0, FIR_COEF_PORT_ADDR, 8'h00, q, v);
    `CHK(q, 8'h5a)
    host.acc(1, FIR_COEF_PORT_ADDR, 8'hc3, q, v);
    host.clr();
    host.acc(0, FIR_COEF_PORT_ADDR, 8'h00, q, v);
    `CHK(q, 8'h5a)
    $display("test register port done");
  endtask
  task automatic t_preset;
    coefficient_source_field_i <= SRC_PRESET;
    filt(68);
    $display("test preset done");
  endtask
  task automatic t_user;
    host.load(0, PRESET_UNITY);
    coefficient_source_field_i <= SRC_USER;
    input_buffer_en_i <= 1;
    filt(75);
    $display("test user bank done");
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    resetn_i = 0;
    conv_resetn_i = 0;
    oversampling_ratio_field_i = 5'h00;
    coefficient_source_field_i = 3'h0;
    bypass_i = 0;
    input_buffer_en_i = 0;
    sample_i = 24'h000000;
    sample_valid_i = 0;
    sync_i = 0;
    repeat (3) @(posedge conv_clk_i);
    conv_resetn_i <= 1;
    @(posedge sys_clk_i);
    resetn_i <= 1;
    t_osr();
    t_bypass();
    t_reg();
    t_preset();
    t_user();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
